//--- common/core_subset_pkg.sv
// Shared constants for the instruction subset core: register map, status
// fields, opcode encodings, widths, reset values and the core state type.
// Assumes a 32-bit APB with byte addresses; each register is one word.
package core_subset_pkg;

    // Widths
    localparam int BUS_W = 32;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int INSTR_W = 14;
    localparam int FADDR_W = 7;
    localparam int LIT_W = 11;
    localparam int LATCH_W = 5;
    localparam int FILE_DEPTH = 128;

    // Default pclk cycles per instruction cycle; six or more are needed
    localparam int CLK_PER_CYCLE_DEF = 8;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_INSTR = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_ACC = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PC = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_LATCH = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_STACK = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_WDOG = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_FADDR = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_FDATA = 8'h20;

    // Status register bit positions
    localparam int ST_ZERO = 0;
    localparam int ST_SLEEP = 1;
    localparam int ST_EXPIRY = 2;
    localparam int ST_PENDING = 3;
    localparam int ST_SLOT = 4;

    // Watchdog register field: prescaler sits above the counter
    localparam int WD_PRE_LSB = 8;

    // Upper latch bits that feed the top of the call target
    localparam int LATCH_HI = 4;
    localparam int LATCH_LO = 3;

    ////////////////////////////////////////////////////////////////////////
    // Opcode encodings
    localparam int OPC_LSB = 8;
    localparam int DEST_BIT = 7;
    localparam logic [2:0] OPC_CALL = 3'h4;
    localparam logic [INSTR_W-1:0] OPC_WDOG_CLR = 14'h0064;
    localparam logic [5:0] OPC_CLEAR = 6'h01;
    localparam logic [5:0] OPC_INVERT = 6'h09;
    localparam logic [5:0] OPC_DEC = 6'h03;
    localparam logic [5:0] OPC_DEC_SKIP = 6'h0B;

    // Constants and reset values
    localparam logic [DATA_W-1:0] ZERO_8 = 8'h00;
    localparam logic [DATA_W-1:0] ONE_8 = 8'h01;
    localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [INSTR_W-1:0] INSTR_RESET = 14'h0000;

    // Core sequence, Gray coded along idle, fetch, execute
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_FETCH = 2'h1,
        ST_EXEC = 2'h3
    } core_state_t;

endpackage

//--- verilog/file_ram.sv
// File register memory: one write port, one read port, registered read.
// Assumes the owner keeps a write and a read of one address apart.
`timescale 1ns/100ps
module file_ram #(
    parameter int DEPTH = 128,
    parameter int WIDTH = 8,
    parameter int AW = $clog2(DEPTH)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // Read port
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    // Array has no reset so it can map onto a plain RAM
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read data come out of a register, old data on a same-edge write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end

endmodule

//--- verilog/instr_subset_core.sv
// Instruction subset core: call, watchdog clear, clears, invert,
// decrement and decrement-with-skip, fed one word at a time over APB.
// Assumes an APB master on pclk; file registers live in file_ram.
// Operation
// - Call pushes next address onto stack head
// - Call target: literal low, latch bits high
// - Call literal 0..2047, flags untouched
// - Call lasts two instruction cycles
// - Watchdog clear zeroes counter and prescaler
// - Watchdog clear sets expiry and sleep flags
// - Clear file writes zero, sets null flag
// - Clear accumulator writes zero, sets null flag
// - Invert file into chosen destination, null flag
// - Decrement file into chosen destination, null flag
// - Decrement-skip same destination, flags untouched
// - Decrement-skip zero result discards next word as idle slot
`timescale 1ns/100ps
module instr_subset_core #(
    parameter int CLK_PER_CYCLE = core_subset_pkg::CLK_PER_CYCLE_DEF,
    parameter int STACK_DEPTH = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [core_subset_pkg::ADDR_W-1:0] paddr,
    input wire logic [core_subset_pkg::BUS_W-1:0] pwdata,
    output logic [core_subset_pkg::BUS_W-1:0] prdata,
    output logic pready,
    output logic pslverr
);
    import core_subset_pkg::*;

    localparam int DIV_W = $clog2(CLK_PER_CYCLE);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLK_PER_CYCLE - 1);

    logic [DIV_W-1:0] div_cnt;
    logic tick;
    core_state_t state;
    logic idle_d;
    logic [INSTR_W-1:0] instr;
    logic [INSTR_W-1:0] next_word;
    logic pending;
    logic hold_slot;
    logic skip_slot;
    logic [PC_W-1:0] pc;
    logic [LATCH_W-1:0] pc_upper_latch;
    logic [PC_W-1:0] stack [STACK_DEPTH];
    logic [DATA_W-1:0] acc;
    logic zero_flag;
    logic expiry_indicator;
    logic sleep_entry_flag;
    logic [DATA_W-1:0] wd_pre;
    logic [DATA_W-1:0] watchdog_counter;
    logic [FADDR_W-1:0] faddr;
    logic [DATA_W-1:0] mem_rdata;
    logic [DATA_W-1:0] result;
    logic [BUS_W-1:0] rd_mux;
    logic mapped;

    ////////////////////////////////////////////////////////////////////////
    // Instruction-cycle enable: one pclk pulse every CLK_PER_CYCLE cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (div_cnt == DIV_LAST);
            div_cnt <= (div_cnt == DIV_LAST) ? '0 : div_cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode of the word under execution
    wire in_idle = (state == ST_IDLE);
    wire in_exec = (state == ST_EXEC);
    wire [FADDR_W-1:0] f_addr = instr[FADDR_W-1:0];
    wire dest_f = instr[DEST_BIT];
    wire [5:0] opc = instr[INSTR_W-1:OPC_LSB];
    wire op_call = (instr[INSTR_W-1:LIT_W] == OPC_CALL);
    wire op_wdt = (instr == OPC_WDOG_CLR);
    wire op_clear_file_op = (opc == OPC_CLEAR) && dest_f;
    wire op_clear_accumulator_op = (opc == OPC_CLEAR) && !dest_f;
    wire op_invert_file_op = (opc == OPC_INVERT);
    wire op_decrement_file_op = (opc == OPC_DEC);
    wire op_dsz = (opc == OPC_DEC_SKIP);
    wire arith = op_invert_file_op || op_decrement_file_op || op_dsz;
    wire [PC_W-1:0] call_target = {pc_upper_latch[LATCH_HI:LATCH_LO], instr[LIT_W-1:0]};

    // Slot ticks burn a cycle; a start needs a queued word
    wire slot_tick = tick && in_idle && (hold_slot || skip_slot);
    wire start = tick && in_idle && !hold_slot && !skip_slot && pending;
    wire consume = start || (slot_tick && skip_slot);

    // APB access strobes, taken at the edge that samples pready high
    wire wr_en = psel && penable && pready && pwrite && mapped;
    wire wr_instr = wr_en && (paddr == OFF_INSTR);
    wire wr_fdata = wr_en && (paddr == OFF_FDATA);

    ////////////////////////////////////////////////////////////////////////
    // Execute result: zero for clears, inverted or decremented file value
    always_comb begin
        result = mem_rdata - ONE_8;
        if (op_clear_file_op || op_clear_accumulator_op) begin
            result = ZERO_8;
        end else if (op_invert_file_op) begin
            result = ~mem_rdata;
        end
    end

    // Destination select: bit clear to accumulator, set back to the file
    wire to_file = in_exec && (op_clear_file_op || (arith && dest_f));
    wire to_acc = in_exec && (op_clear_accumulator_op || (arith && !dest_f));
    wire zero_upd = in_exec && (op_clear_file_op || op_clear_accumulator_op || op_invert_file_op || op_decrement_file_op);
    wire skip_take = in_exec && op_dsz && (result == ZERO_8);

    // File memory ports: execute owns the write port, fetch the read port, APB window otherwise
    wire mem_we = to_file || wr_fdata;
    wire [FADDR_W-1:0] mem_waddr = in_exec ? f_addr : faddr;
    wire [DATA_W-1:0] mem_wdata = in_exec ? result : pwdata[DATA_W-1:0];
    wire [FADDR_W-1:0] mem_raddr = (state == ST_FETCH) ? f_addr : faddr;

    file_ram #(
        .DEPTH(FILE_DEPTH),
        .WIDTH(DATA_W)
    ) u_file_ram (
        .clk(pclk),
        .rst_n(presetn),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequence: fetch reads the file operand, execute commits everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            idle_d <= 1'b1;
        end else begin
            idle_d <= in_idle;
            unique case (state)
                ST_IDLE: begin
                    if (start) begin
                        state <= ST_FETCH;
                    end
                end
                ST_FETCH: state <= ST_EXEC;
                ST_EXEC: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Word queue: a write that meets a consume in one edge stays queued
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            next_word <= INSTR_RESET;
            instr <= INSTR_RESET;
            pending <= 1'b0;
        end else begin
            if (wr_instr) begin
                next_word <= pwdata[INSTR_W-1:0];
            end
            if (start) begin
                instr <= next_word;
            end
            if (wr_instr) begin
                pending <= 1'b1;
            end else if (consume) begin
                pending <= 1'b0;
            end
        end
    end

    // Extra slots: call holds one cycle, a taken skip drops the next word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_slot <= 1'b0;
            skip_slot <= 1'b0;
        end else begin
            if (in_exec && op_call) begin
                hold_slot <= 1'b1;
            end else if (slot_tick) begin
                hold_slot <= 1'b0;
            end
            if (skip_take) begin
                skip_slot <= 1'b1;
            end else if (slot_tick) begin
                skip_slot <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program counter; an APB write wins since software owns a stalled core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= PC_RESET;
            pc_upper_latch <= '0;
        end else begin
            if (in_exec && op_call) begin
                pc <= call_target;
            end else if (in_exec || (slot_tick && skip_slot)) begin
                pc <= pc + PC_ONE;
            end
            if (wr_en && (paddr == OFF_PC)) begin
                pc <= pwdata[PC_W-1:0];
            end
            if (wr_en && (paddr == OFF_LATCH)) begin
                pc_upper_latch <= pwdata[LATCH_W-1:0];
            end
        end
    end

    // Return stack: head takes pc+1, older entries shift down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack[0] <= PC_RESET;
        end else if (in_exec && op_call) begin
            stack[0] <= pc + PC_ONE;
        end
    end

    for (genvar i = 1; i < STACK_DEPTH; i++) begin : g_stack
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                stack[i] <= PC_RESET;
            end else if (in_exec && op_call) begin
                stack[i] <= stack[i-1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accumulator and result-null flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= ZERO_8;
            zero_flag <= 1'b0;
        end else begin
            if (to_acc) begin
                acc <= result;
            end else if (wr_en && (paddr == OFF_ACC)) begin
                acc <= pwdata[DATA_W-1:0];
            end
            if (zero_upd) begin
                zero_flag <= (result == ZERO_8);
            end
        end
    end

    // Watchdog: prescaler counts instruction cycles, counter its wraps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_pre <= ZERO_8;
            watchdog_counter <= ZERO_8;
            expiry_indicator <= 1'b1;
            sleep_entry_flag <= 1'b1;
        end else if (in_exec && op_wdt) begin
            wd_pre <= ZERO_8;
            watchdog_counter <= ZERO_8;
            expiry_indicator <= 1'b1;
            sleep_entry_flag <= 1'b1;
        end else if (tick) begin
            wd_pre <= wd_pre + ONE_8;
            if (&wd_pre) begin
                watchdog_counter <= watchdog_counter + ONE_8;
                if (&watchdog_counter) begin
                    expiry_indicator <= 1'b0; // Low means expired
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB read mux and address decode; unmapped answers with pslverr
    always_comb begin
        rd_mux = '0;
        mapped = 1'b1;
        unique case (paddr)
            OFF_INSTR: rd_mux[INSTR_W-1:0] = next_word;
            OFF_STATUS: begin
                rd_mux[ST_ZERO] = zero_flag;
                rd_mux[ST_SLEEP] = sleep_entry_flag;
                rd_mux[ST_EXPIRY] = expiry_indicator;
                rd_mux[ST_PENDING] = pending;
                rd_mux[ST_SLOT] = hold_slot || skip_slot;
            end
            OFF_ACC: rd_mux[DATA_W-1:0] = acc;
            OFF_PC: rd_mux[PC_W-1:0] = pc;
            OFF_LATCH: rd_mux[LATCH_W-1:0] = pc_upper_latch;
            OFF_STACK: rd_mux[PC_W-1:0] = stack[0];
            OFF_WDOG: rd_mux[WD_PRE_LSB+DATA_W-1:0] = {wd_pre, watchdog_counter};
            OFF_FADDR: rd_mux[FADDR_W-1:0] = faddr;
            OFF_FDATA: rd_mux[DATA_W-1:0] = mem_rdata;
            default: mapped = 1'b0;
        endcase
    end

    // Answer only when the core is quiet so APB never races execute;
    // a word write also waits until the previous word was taken
    wire can_go = in_idle && idle_d && !tick && !(pwrite && (paddr == OFF_INSTR) && pending);
    wire respond = psel && penable && !pready && can_go;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= respond;
            pslverr <= respond && !mapped;
            if (respond) begin
                prdata <= pwrite ? '0 : rd_mux;
            end
        end
    end

    // File window address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            faddr <= '0;
        end else if (wr_en && (paddr == OFF_FADDR)) begin
            faddr <= pwdata[FADDR_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking ast_clk @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_CALL_PUSH: assert property (in_exec && op_call |=> stack[0] == $past(pc) + PC_ONE)
        else $error("call did not push pc plus one");
    AST_CALL_TARGET: assert property (in_exec && op_call |=> pc == $past(call_target))
        else $error("call target wrong");
    AST_CALL_FLAGS: assert property (in_exec && op_call |=> $stable(zero_flag)
        && $stable(expiry_indicator) && $stable(sleep_entry_flag))
        else $error("call changed a status flag");
    AST_CALL_SLOT: assert property (in_exec && op_call ##1 hold_slot [*2]
        |-> !start throughout (!slot_tick [*1]))
        else $error("call second cycle not held");
    AST_HOLD_IDLE: assert property (slot_tick && hold_slot |=> in_idle && !hold_slot)
        else $error("call idle slot misbehaved");
    AST_WDT_CLR: assert property (in_exec && op_wdt |=> watchdog_counter == ZERO_8
        && wd_pre == ZERO_8)
        else $error("watchdog not cleared");
    AST_WDT_FLAGS: assert property (in_exec && op_wdt |=> expiry_indicator
        && sleep_entry_flag && $stable(zero_flag))
        else $error("watchdog clear flags wrong");
    AST_CLEAR_FILE_OP: assert property (in_exec && op_clear_file_op |-> (mem_we && mem_wdata == ZERO_8
        && mem_waddr == f_addr) ##1 zero_flag)
        else $error("clear file wrong");
    AST_CLEAR_ACCUMULATOR_OP: assert property (in_exec && op_clear_accumulator_op |=> acc == ZERO_8 && zero_flag)
        else $error("clear accumulator wrong");
    AST_INVERT: assert property (in_exec && op_invert_file_op && !dest_f |=>
        acc == ~$past(mem_rdata) && zero_flag == (acc == ZERO_8))
        else $error("invert to accumulator wrong");
    AST_DEC_FILE: assert property (in_exec && op_decrement_file_op && dest_f |->
        (mem_we && mem_wdata == mem_rdata - ONE_8) ##1 $stable(acc))
        else $error("decrement to file wrong");
    AST_DSZ_FLAGS: assert property (in_exec && op_dsz |=> $stable(zero_flag))
        else $error("decrement-skip changed a flag");
    AST_SKIP_SET: assert property (in_exec && op_dsz |=>
        skip_slot == ($past(mem_rdata) == ONE_8))
        else $error("skip decision wrong");
    AST_SKIP_DROP: assert property (slot_tick && skip_slot && !wr_instr |=>
        !pending && in_idle && !skip_slot)
        else $error("skipped word not discarded");
    AST_ONE_CYCLE: assert property (start |=> state == ST_FETCH ##1 in_exec ##1 in_idle)
        else $error("instruction not single cycle");

endmodule

//--- dv/prog_mem_model.sv
// Program memory model: sixteen instruction words, loaded by the bench,
// read by fetch address. Assumes the bench loads a word before it fetches it.
`timescale 1ns/100ps
module prog_mem_model (
    // Clock
    input wire logic clk,
    // Load port
    input wire logic ld,
    input wire logic [3:0] ld_addr,
    input wire logic [core_subset_pkg::INSTR_W-1:0] ld_word,
    // Fetch port
    input wire logic [core_subset_pkg::PC_W-1:0] fetch_pc,
    output logic [core_subset_pkg::INSTR_W-1:0] word
);
    import core_subset_pkg::*;
    logic [INSTR_W-1:0] mem [16];

    // Small window: the fetch address wraps, so only low pc bits select
    always_ff @(posedge clk) begin
        if (ld) begin
            mem[ld_addr] <= ld_word;
        end
    end
    assign word = mem[fetch_pc[3:0]];
endmodule

//--- dv/cpu_instruction_subset_exec_test.sv
// Self-checking bench for the instruction subset core over APB.
// Assumes the core's register map and opcodes from the shared package.
`timescale 1ns/100ps
module cpu_instruction_subset_exec_test;
    import core_subset_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [BUS_W-1:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, ld = 1'b0;
    logic [3:0] ld_addr = 4'h0;
    logic [INSTR_W-1:0] ld_word = 14'h0, word;
    logic [PC_W-1:0] pc_exp = 13'h0;
    logic [31:0] rnd = 32'hBE1AB2EC;
    int bad_count = 0, cmp_count = 0;

    // Slow tick leaves room to queue a word before the slot tick
    instr_subset_core #(.CLK_PER_CYCLE(16), .STACK_DEPTH(8)) uut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    prog_mem_model mem (.clk(pclk), .ld(ld), .ld_addr(ld_addr), .ld_word(ld_word),
        .fetch_pc(pc_exp), .word(word));

    always #2 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////
    // Comparison, random source and APB master
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Request held until pready is sampled high; data taken at that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 500);
        if (n >= 500) bad_count++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Fetch from program memory, feed the core, wait until the word is taken
    task automatic exec(input logic [13:0] w, output logic [31:0] st);
        int n;
        @(posedge pclk);
        ld <= 1'b1;
        ld_addr <= pc_exp[3:0];
        ld_word <= w;
        @(posedge pclk);
        ld <= 1'b0;
        // The load lands in this edge's update; read the word one edge later
        @(posedge pclk);
        wr(OFF_INSTR, {18'h0, word});
        n = 0;
        do begin
            rd(OFF_STATUS, st);
            n++;
        end while (st[3] !== 1'b0 && n < 100);
    endtask
    task automatic settle();
        logic [31:0] st;
        int n;
        n = 0;
        do begin
            rd(OFF_STATUS, st);
            n++;
        end while (st[4:3] !== 2'b00 && n < 100);
    endtask
    function automatic logic [7:0] exp_result(input logic [5:0] opc, input logic [7:0] v);
        case (opc)
            OPC_INVERT: return ~v;
            OPC_DEC, OPC_DEC_SKIP: return v - 8'h01;
            default: return 8'h00;
        endcase
    endfunction

    // File-register op; a taken skip also gets a queued word that must vanish
    task automatic file_op(input logic [5:0] opc, input logic d, input logic [7:0] v);
        logic [6:0] a;
        logic [7:0] acc0, res;
        logic [31:0] st0, st, r, pc0;
        logic skip;
        a = rnd[6:0];
        acc0 = rnd[15:8] | 8'h01;
        rnd = lfsr(rnd);
        res = exp_result(opc, v);
        skip = (opc == OPC_DEC_SKIP) && (res == 8'h00);
        wr(OFF_FADDR, {25'h0, a});
        wr(OFF_FDATA, {24'h0, v});
        wr(OFF_ACC, {24'h0, acc0});
        rd(OFF_STATUS, st0);
        rd(OFF_PC, pc0);
        pc_exp = pc0[12:0];
        exec({opc, d, a}, st);
        check("slot", st[4], skip);
        if (skip) wr(OFF_INSTR, 32'h0100);
        settle();
        rd(OFF_ACC, r);
        check("acc", r, d ? acc0 : res);
        rd(OFF_FDATA, r);
        check("file", r, d ? res : v);
        rd(OFF_STATUS, r);
        check("flags", r[2:0], {st0[2:1], (opc == OPC_DEC_SKIP) ? st0[0] : (res == 8'h00)});
        rd(OFF_PC, r);
        check("pc", r, (pc0 + (skip ? 2 : 1)) & 32'h1FFF);
    endtask

    // Call with a queued follower that must wait out the second cycle
    task automatic call_op(input logic [10:0] k);
        logic [31:0] st0, st, r, pc0;
        logic [4:0] lat;
        logic [12:0] tgt;
        lat = rnd[4:0];
        wr(OFF_PC, {19'h0, rnd[20:8]});
        rnd = lfsr(rnd);
        wr(OFF_LATCH, {27'h0, lat});
        wr(OFF_ACC, 32'h5A);
        rd(OFF_PC, pc0);
        rd(OFF_STATUS, st0);
        pc_exp = pc0[12:0];
        tgt = {lat[4:3], k};
        exec({OPC_CALL, k}, st);
        check("call slot", st[4], 1'b1);
        check("call flags", st[2:0], st0[2:0]);
        rd(OFF_PC, r);
        check("call pc", r, {19'h0, tgt});
        pc_exp = tgt;
        exec(14'h0100, st);
        check("follower waits", st[4], 1'b0);
        settle();
        rd(OFF_STACK, r);
        check("stack", r, (pc0 + 1) & 32'h1FFF);
        rd(OFF_ACC, r);
        check("follower", r, 32'h0);
        rd(OFF_PC, r);
        check("after call", r, {19'h0, tgt + 13'h1});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Verdict, watchdog and main sequence
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #300000;
        bad_count++;
        complete_run();
    end

    initial begin
        logic [31:0] r, st, st0;
        logic e;
        logic [5:0] ops [4];
        logic [7:0] vals [4];
        ops = '{OPC_CLEAR, OPC_INVERT, OPC_DEC, OPC_DEC_SKIP};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        wr(OFF_STATUS, 32'h0);
        rd(OFF_STATUS, r);
        check("status reset", r, 32'h6);
        apb(1'b0, 8'h24, 32'h0, r, e);
        check("unmapped", {r[30:0], e}, 32'h1);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            vals = '{8'h01, 8'hFF, 8'h00, rnd[23:16]};
            rnd = lfsr(rnd);
            for (int j = 0; j < 8; j++) begin
                file_op(ops[i], j[0], vals[j / 2]);
            end
            $display("test file op %h done", ops[i]);
        end
        rd(OFF_STATUS, st0);
        pc_exp = 13'h0;
        exec(OPC_WDOG_CLR, st);
        rd(OFF_WDOG, r);
        check("wdog", {r[15:9], r[7:0]}, 32'h0);
        check("wdog flags", st[2:0], {2'b11, st0[0]});
        check("wdog slot", st[4], 1'b0);
        $display("test watchdog clear done");
        call_op(11'h000);
        call_op(11'h7FF);
        for (int i = 0; i < 3; i++) begin
            call_op(rnd[26:16]);
            rnd = lfsr(rnd);
        end
        $display("test call done");
        complete_run();
    end
endmodule
